/* core/dpr_ctrl.v */
// dpr_ctrl.v: bank closing and auto refresh engine of a ddr2 device core
// assumes command pins are sampled on i_clk after two-flop synchronisation;
// the controller keeps its own spacing, refresh with a bank not idle or inside tRFC and activate inside tRFC are flagged and the command dropped
//
// Behaviour
// - precharge decodes as cs, ras, we low and cas high
// - precharge with A10 high closes all banks, else selected bank only
// - read or write with A10 low leaves the bank open
// - read with A10 high engages auto-precharge
// - read auto-precharge starts AL plus BL/2 after command if timings met
// - auto-precharge deferred until tRAS and tRTP are satisfied
// - tRP counts from the actual internal precharge point
// - internal precharge never before two clocks after last 4-bit prefetch
// - write auto-precharge waits until last data is stored
// - write auto-precharge starts after burst end plus tWR
// - refresh decodes as cs, ras, cas low and we high
// - refresh addresses come from an internal counter
// - refresh leaves banks idle; next activate or refresh after tRFC
`timescale 1ns/100ps
`include "dpr_consts.vh"
module dpr_ctrl #(
  parameter NB = 8,
  parameter BW = 3,
  parameter RW = 16,
  parameter CW = 8
) (
  // clock and reset
  input  wire          i_clk,
  input  wire          i_arst_n,
  // command pins
  input  wire          i_cs_n,
  input  wire          i_ras_n,
  input  wire          i_cas_n,
  input  wire          i_we_n,
  input  wire [BW-1:0] i_ba,
  input  wire [15:0]   i_addr,
  // mode settings in clocks
  input  wire [3:0]    i_al,
  input  wire [3:0]    i_cl,
  input  wire          i_bl8,
  // bank and refresh state
  output reg  [NB-1:0] o_bank_open,
  output reg  [NB-1:0] o_ap_pending,
  output reg  [NB-1:0] o_pre_start,
  output reg           o_refreshing,
  output reg  [RW-1:0] o_ref_row,
  output reg           o_ref_pulse,
  // controller misuse flags, sticky until reset
  output reg           o_err_ref_busy,
  output reg           o_err_act_busy
);
  localparam [CW-1:0] RFC_C = `DPR_TRFC_CYC;
  localparam [CW-1:0] RTP_C = `DPR_TRTP_CYC;
  localparam [CW-1:0] WR_C  = `DPR_TWR_CYC;

  // refresh engine states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_REF  = 2'b10;

  wire [BW+16+3:0] pins_s;
  wire             cs_n  = pins_s[BW+16+3];
  wire             ras_n = pins_s[BW+16+2];
  wire             cas_n = pins_s[BW+16+1];
  wire             we_n  = pins_s[BW+16];
  wire [15:0]      addr  = pins_s[15:0];
  wire [BW-1:0]    ba    = pins_s[BW+15:16];

  dpr_sync2 #(.W(BW+20)) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr}),
    .o_q      (pins_s)
  );

  wire [3:0] cmd  = {cs_n, ras_n, cas_n, we_n};
  wire is_act     = (cmd == `DPR_CMD_ACT);
  wire is_rd      = (cmd == `DPR_CMD_RD);
  wire is_wr      = (cmd == `DPR_CMD_WR);
  wire is_pre     = (cmd == `DPR_CMD_PRE);
  wire is_ref     = (cmd == `DPR_CMD_REF);
  wire a10        = addr[`DPR_AP_BIT];

  // mode-derived delays
  wire [CW-1:0] half_bl  = i_bl8 ? 8'h04 : 8'h02;
  wire [CW-1:0] al_w     = {{(CW-4){1'b0}}, i_al};
  wire [CW-1:0] cl_w     = {{(CW-4){1'b0}}, i_cl};
  wire [CW-1:0] rd_ap    = al_w + half_bl - 8'h01;
  // last prefetch is AL (bl4) or AL+2 (bl8); floor at tRTP and two clocks
  wire [CW-1:0] pf_at    = al_w + (i_bl8 ? 8'h02 : 8'h00);
  wire [CW-1:0] rtp_min  = (RTP_C > 8'h02) ? RTP_C : 8'h02;
  wire [CW-1:0] rtp_fl   = pf_at + rtp_min - 8'h01;
  // WL = AL+CL-1, burst end plus tWR
  wire [CW-1:0] wr_ap    = al_w + cl_w - 8'h01 + half_bl + WR_C - 8'h01;

  reg  [1:0]    st;
  reg  [1:0]    next_st;
  reg  [CW-1:0] rfc_cnt;
  wire [NB-1:0] b_open;
  wire [NB-1:0] b_ap;
  wire [NB-1:0] b_pre;
  wire [NB-1:0] b_idle;
  wire          all_idle = &b_idle;
  wire          busy     = (st == ST_REF);

  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : g_bank
      localparam [BW-1:0] BANK_ID = g;
      wire sel = (ba == BANK_ID);
      dpr_bank #(.CW(CW)) u_bank (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_act       (is_act && sel && !busy),
        .i_pre       (is_pre && (a10 || sel)),
        .i_rd        (is_rd && sel),
        .i_wr        (is_wr && sel),
        .i_ap        (a10),
        .i_rd_ap_dly (rd_ap),
        .i_rtp_floor (rtp_fl),
        .i_wr_ap_dly (wr_ap),
        .o_open      (b_open[g]),
        .o_ap_pend   (b_ap[g]),
        .o_pre_start (b_pre[g]),
        .o_idle      (b_idle[g])
      );
    end
  endgenerate

  // refresh state machine
  always @* begin
    next_st = st;
    case (st)
      ST_IDLE: if (is_ref && all_idle) next_st = ST_REF;
      ST_REF:  if (rfc_cnt == 8'h01) next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st             <= ST_IDLE;
      rfc_cnt        <= {CW{1'b0}};
      o_ref_row      <= `DPR_REF_ROW_RST;
      o_ref_pulse    <= 1'b0;
      o_refreshing   <= 1'b0;
      o_bank_open    <= {NB{1'b0}};
      o_ap_pending   <= {NB{1'b0}};
      o_pre_start    <= {NB{1'b0}};
      o_err_ref_busy <= 1'b0;
      o_err_act_busy <= 1'b0;
    end else begin
      st           <= next_st;
      o_ref_pulse  <= 1'b0;
      o_bank_open  <= b_open;
      o_ap_pending <= b_ap;
      o_pre_start  <= b_pre;
      o_refreshing <= (next_st == ST_REF);
      if (st == ST_IDLE && is_ref && all_idle) begin
        rfc_cnt     <= RFC_C;
        o_ref_row   <= o_ref_row + 1'b1;
        o_ref_pulse <= 1'b1;
      end else if (rfc_cnt != {CW{1'b0}}) begin
        rfc_cnt <= rfc_cnt - 1'b1;
      end
      // refresh with a bank not idle, or inside tRFC
      if (is_ref && (busy || !all_idle))
        o_err_ref_busy <= 1'b1;
      if (is_act && busy)
        o_err_act_busy <= 1'b1;
    end
  end
endmodule // dpr_ctrl

/* core/dpr_consts.vh */
// dpr_consts.vh: command codes, timing figures and derived cycle counts
// assumes a 10 MHz core clock; counts are rounded as each figure demands
`ifndef DPR_CONSTS_VH
`define DPR_CONSTS_VH

// command encodings {cs_n, ras_n, cas_n, we_n}
`define DPR_CMD_ACT      4'h3
`define DPR_CMD_RD       4'h5
`define DPR_CMD_WR       4'h4
`define DPR_CMD_PRE      4'h2
`define DPR_CMD_REF      4'h1

// address bit that carries auto-precharge / all-banks
`define DPR_AP_BIT       10

// clock period and analog minimums in ns
`define DPR_CLK_NS       100
`define DPR_TRAS_NS      45
`define DPR_TRTP_NS      8
`define DPR_TRP_NS       15
`define DPR_TRC_NS       60
`define DPR_TWR_NS       15
`define DPR_TRFC_NS      128

// least times round up to whole cycles, never below one
`define DPR_CEIL(ns)     ((((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS) < 1 ? 1 : \
                          (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS))
`define DPR_TRAS_CYC     `DPR_CEIL(`DPR_TRAS_NS)
`define DPR_TRTP_CYC     `DPR_CEIL(`DPR_TRTP_NS)
`define DPR_TRP_CYC      `DPR_CEIL(`DPR_TRP_NS)
`define DPR_TRC_CYC      `DPR_CEIL(`DPR_TRC_NS)
`define DPR_TWR_CYC      `DPR_CEIL(`DPR_TWR_NS)
`define DPR_TRFC_CYC     `DPR_CEIL(`DPR_TRFC_NS)

// reset value of the refresh row counter
`define DPR_REF_ROW_RST  16'h0000

`endif

/* core/dpr_sync2.v */
// dpr_sync2.v: two-flop synchroniser for a bus of pin inputs
// assumes the inputs arrive from outside the core clock domain
`timescale 1ns/100ps
module dpr_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_arst_n,
  // data
  input  wire [W-1:0] i_d,
  output reg  [W-1:0] o_q
);
  reg [W-1:0] meta;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= {W{1'b0}};
      o_q  <= {W{1'b0}};
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule // dpr_sync2

/* core/dpr_bank.v */
// dpr_bank.v: one bank's open/closed state and auto-precharge timing
// assumes decoded one-cycle strokes from the command decoder on the same clock
`timescale 1ns/100ps
`include "dpr_consts.vh"
module dpr_bank #(
  parameter CW = 8
) (
  // clock and reset
  input  wire          i_clk,
  input  wire          i_arst_n,
  // decoded strokes for this bank
  input  wire          i_act,
  input  wire          i_pre,
  input  wire          i_rd,
  input  wire          i_wr,
  input  wire          i_ap,
  // mode timing in cycles
  input  wire [CW-1:0] i_rd_ap_dly,
  input  wire [CW-1:0] i_rtp_floor,
  input  wire [CW-1:0] i_wr_ap_dly,
  // state
  output reg           o_open,
  output reg           o_ap_pend,
  output reg           o_pre_start,
  output wire          o_idle
);
  localparam [CW-1:0] RAS_C = `DPR_TRAS_CYC;
  localparam [CW-1:0] RP_C  = `DPR_TRP_CYC;

  reg [CW-1:0] ras_cnt;
  reg [CW-1:0] ap_cnt;
  reg [CW-1:0] rtp_cnt;
  reg [CW-1:0] rp_cnt;

  wire ras_ok   = (ras_cnt == {CW{1'b0}});
  wire ap_fire  = o_ap_pend && (ap_cnt == {CW{1'b0}}) && ras_ok
                  && (rtp_cnt == {CW{1'b0}});
  wire close_now = i_pre || ap_fire;

  assign o_idle = !o_open && (rp_cnt == {CW{1'b0}});

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_open      <= 1'b0;
      o_ap_pend   <= 1'b0;
      o_pre_start <= 1'b0;
      ras_cnt     <= {CW{1'b0}};
      ap_cnt      <= {CW{1'b0}};
      rtp_cnt     <= {CW{1'b0}};
      rp_cnt      <= {CW{1'b0}};
    end else begin
      o_pre_start <= close_now && o_open;
      if (ras_cnt != {CW{1'b0}}) ras_cnt <= ras_cnt - 1'b1;
      if (ap_cnt  != {CW{1'b0}}) ap_cnt  <= ap_cnt - 1'b1;
      if (rtp_cnt != {CW{1'b0}}) rtp_cnt <= rtp_cnt - 1'b1;
      if (rp_cnt  != {CW{1'b0}}) rp_cnt  <= rp_cnt - 1'b1;
      if (i_act) begin
        o_open  <= 1'b1;
        ras_cnt <= RAS_C - 1'b1;
      end else if (close_now && o_open) begin
        o_open    <= 1'b0;
        o_ap_pend <= 1'b0;
        rp_cnt    <= RP_C;
      end
      if (i_rd && i_ap) begin
        o_ap_pend <= 1'b1;
        ap_cnt    <= i_rd_ap_dly;
        rtp_cnt   <= i_rtp_floor;
      end else if (i_wr && i_ap) begin
        o_ap_pend <= 1'b1;
        ap_cnt    <= i_wr_ap_dly;
        rtp_cnt   <= {CW{1'b0}};
      end
    end
  end
endmodule // dpr_bank

/* dv/dpr_host.sv */
// dpr_host.sv: controller model driving the command pins
// assumes the device samples pins on the rising edge of i_clk
`timescale 1ns/100ps
module dpr_host (
  // clock
  input  wire        i_clk,
  // command pins
  output reg         o_cs_n,
  output reg         o_ras_n,
  output reg         o_cas_n,
  output reg         o_we_n,
  output reg  [2:0]  o_ba,
  output reg  [15:0] o_addr
);
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_ba   = 3'h0;
    o_addr = 16'h0000;
  end
  task cmd(input [3:0] c, input [2:0] b, input [15:0] a);
    begin
      @(posedge i_clk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= c;
      o_ba   <= b;
      o_addr <= a;
    end
  endtask
  // deselected, address keeps toggling
  task idle;
    begin
      @(posedge i_clk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'hF;
      o_ba   <= ~o_ba;
      o_addr <= ~o_addr;
    end
  endtask
  // spacing callers choose to meet device minimums
  task gap(input integer n);
    begin
      repeat (n) idle;
      #1;
    end
  endtask
  task op(input [3:0] c, input [2:0] b, input [15:0] a, input integer n);
    begin
      cmd(c, b, a);
      gap(n);
    end
  endtask
endmodule // dpr_host

/* dv/dpr_ctrl_properties.sv */
// dpr_ctrl_properties.sv: port timing checks for the bank and refresh engine
// assumes commands are spaced by the controller
`timescale 1ns/100ps
`include "dpr_consts.vh"
module dpr_ctrl_props #(
  parameter NB = 8,
  parameter BW = 3,
  parameter RW = 16,
  parameter CW = 8
) (
  // clock, pins, modes
  input wire          i_clk,
  input wire          i_arst_n,
  input wire          i_cs_n,
  input wire          i_ras_n,
  input wire          i_cas_n,
  input wire          i_we_n,
  input wire [BW-1:0] i_ba,
  input wire [15:0]   i_addr,
  input wire [3:0]    i_al,
  input wire [3:0]    i_cl,
  input wire          i_bl8,
  // state
  input wire [NB-1:0] o_bank_open,
  input wire [NB-1:0] o_ap_pending,
  input wire [NB-1:0] o_pre_start,
  input wire          o_refreshing,
  input wire [RW-1:0] o_ref_row,
  input wire          o_ref_pulse,
  input wire          o_err_ref_busy,
  input wire          o_err_act_busy
);
  wire [3:0] c  = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  wire       ap = i_addr[`DPR_AP_BIT];
  wire       cas_ap = ap && (c == `DPR_CMD_RD || c == `DPR_CMD_WR);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_pre_all_close: assert property (c == `DPR_CMD_PRE && ap |-> ##4 ~|o_bank_open)
    else $error("all-bank precharge left a bank open");
  a_pre_one_bank: assert property (c == `DPR_CMD_PRE && !ap
    |-> ##4 !o_bank_open[$past(i_ba, 4)])
    else $error("bank precharge left bank open");
  a_act_opens: assert property (c == `DPR_CMD_ACT
    |-> ##4 (o_bank_open[$past(i_ba, 4)] || o_err_act_busy))
    else $error("activate did not open bank");
  a_plain_keeps_open: assert property ((c == `DPR_CMD_RD || c == `DPR_CMD_WR) && !ap
    && o_bank_open[i_ba] |-> ##4 o_bank_open[$past(i_ba, 4)] && !o_ap_pending[$past(i_ba, 4)])
    else $error("plain access closed bank");
  a_ap_arms: assert property (cas_ap && o_bank_open[i_ba]
    |-> ##4 o_ap_pending[$past(i_ba, 4)])
    else $error("auto precharge not armed");
  a_ap_fires: assert property (cas_ap |-> ##[5:30] |o_pre_start)
    else $error("auto precharge never started");
  a_pre_closes: assert property (|o_pre_start |-> ~|(o_bank_open & o_pre_start))
    else $error("closing bank still open");
  a_ref_length: assert property ($rose(o_refreshing) |-> o_refreshing[*2] ##1 !o_refreshing)
    else $error("refresh window length wrong");
  a_ref_idle: assert property (o_refreshing |-> ~|o_bank_open)
    else $error("bank open during refresh");
  a_ref_taken: assert property (c == `DPR_CMD_REF && ~|o_bank_open && ~|o_ap_pending
    && !o_refreshing |-> ##[2:4] o_ref_pulse)
    else $error("refresh not taken");
  c_ref: cover property (o_ref_pulse);
  c_act_busy: cover property (o_err_act_busy);
  c_ap: cover property (cas_ap);
endmodule // dpr_ctrl_props
bind dpr_ctrl dpr_ctrl_props #(.NB(NB), .BW(BW), .RW(RW), .CW(CW)) dpr_ctrl_props_i (.*);

/* dv/dpr_ctrl_tb.sv */
// dpr_ctrl_tb.sv: directed checks of bank closing and auto refresh
// assumes the host model spaces commands as the device expects
`timescale 1ns/100ps
`include "dpr_consts.vh"
module dpr_ctrl_tb;
  reg         i_clk;
  reg         i_arst_n;
  reg  [3:0]  i_al;
  reg  [3:0]  i_cl;
  reg         i_bl8;
  wire        i_cs_n, i_ras_n, i_cas_n, i_we_n;
  wire [2:0]  i_ba;
  wire [15:0] i_addr;
  wire [7:0]  o_bank_open, o_ap_pending, o_pre_start;
  wire        o_refreshing, o_ref_pulse, o_err_ref_busy, o_err_act_busy;
  wire [15:0] o_ref_row;
  integer     error_cnt, checked, d0, d1, e, n;
  dpr_ctrl dpr_ctrl_i (.*);
  dpr_host dpr_host_i (
    .i_clk   (i_clk),
    .o_cs_n  (i_cs_n),
    .o_ras_n (i_ras_n),
    .o_cas_n (i_cas_n),
    .o_we_n  (i_we_n),
    .o_ba    (i_ba),
    .o_addr  (i_addr)
  );
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // edges from command to bank close pulse
  task pre_dly(input [3:0] c, input [2:0] b, input [15:0] a, output integer k);
    begin
      k = 0;
      dpr_host_i.cmd(c, b, a);
      dpr_host_i.idle;
      #1;
      while (o_pre_start[b] !== 1'b1 && k < 60) begin
        @(posedge i_clk);
        #1;
        k = k + 1;
      end
    end
  endtask
  task t_explicit;
    begin
      dpr_host_i.op(`DPR_CMD_ACT, 3'h2, 16'h0000, 6);
      dpr_host_i.op(`DPR_CMD_RD, 3'h2, 16'h0000, 8);
      cmp({8'h00, o_bank_open}, 16'h0004);
      cmp({8'h00, o_ap_pending}, 16'h0000);
      pre_dly(`DPR_CMD_PRE, 3'h2, 16'h0000, d0);
      // two sync flops, decode, output register
      cmp(16'(d0), 16'h0003);
      dpr_host_i.gap(4);
      cmp({8'h00, o_bank_open}, 16'h0000);
      dpr_host_i.op(`DPR_CMD_ACT, 3'h1, 16'h0000, 6);
      dpr_host_i.op(`DPR_CMD_ACT, 3'h5, 16'h0000, 6);
      dpr_host_i.op(`DPR_CMD_PRE, 3'h3, 16'h0000, 6);
      cmp({8'h00, o_bank_open}, 16'h0022);
      dpr_host_i.op(`DPR_CMD_PRE, 3'h1, 16'h0400, 6);
      cmp({8'h00, o_bank_open}, 16'h0000);
      $display("explicit precharge test done");
    end
  endtask
  task t_auto(input [3:0] al, input [3:0] cl, input b8);
    begin
      @(posedge i_clk);
      i_al  <= al;
      i_cl  <= cl;
      i_bl8 <= b8;
      dpr_host_i.op(`DPR_CMD_ACT, 3'h3, 16'h0000, 6);
      pre_dly(`DPR_CMD_RD, 3'h3, 16'h0400, d1);
      e = al + (b8 ? 4 : 2);
      cmp(16'(d1 - d0), 16'(e));
      dpr_host_i.op(`DPR_CMD_ACT, 3'h6, 16'h0000, 6);
      pre_dly(`DPR_CMD_WR, 3'h6, 16'h0400, d1);
      e = al + cl - 1 + (b8 ? 4 : 2) + `DPR_TWR_CYC;
      cmp(16'(d1 - d0), 16'(e));
      dpr_host_i.gap(4);
      cmp({8'h00, o_bank_open}, 16'h0000);
      $display("auto precharge test done");
    end
  endtask
  task t_refresh;
    begin
      cmp({15'h0000, o_err_act_busy}, 16'h0000);
      dpr_host_i.cmd(`DPR_CMD_REF, 3'h5, 16'hFFFF);
      dpr_host_i.cmd(`DPR_CMD_ACT, 3'h1, 16'h0000);
      dpr_host_i.gap(8);
      cmp(o_ref_row, `DPR_REF_ROW_RST + 16'h0001);
      cmp({15'h0000, o_err_act_busy}, 16'h0001);
      cmp({8'h00, o_bank_open}, 16'h0000);
      dpr_host_i.cmd(`DPR_CMD_REF, 3'h0, 16'h0000);
      dpr_host_i.idle;
      n = 0;
      d1 = 0;
      repeat (20) begin
        #1;
        n = n + (o_refreshing === 1'b1);
        d1 = d1 + (o_ref_pulse === 1'b1);
        @(posedge i_clk);
      end
      cmp(16'(n), 16'(`DPR_TRFC_CYC));
      cmp(16'(d1), 16'h0001);
      cmp(o_ref_row, `DPR_REF_ROW_RST + 16'h0002);
      cmp({15'h0000, o_err_ref_busy}, 16'h0000);
      dpr_host_i.op(`DPR_CMD_ACT, 3'h4, 16'h0000, 6);
      dpr_host_i.op(`DPR_CMD_REF, 3'h4, 16'h0000, 8);
      cmp(o_ref_row, `DPR_REF_ROW_RST + 16'h0002);
      cmp({15'h0000, o_err_ref_busy}, 16'h0001);
      $display("refresh test done");
    end
  endtask
  // mid-run reset clears flags, counter and open banks
  task t_reset;
    begin
      @(posedge i_clk);
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_arst_n <= 1'b1;
      #1;
      cmp(o_ref_row, `DPR_REF_ROW_RST);
      cmp({14'h0000, o_err_ref_busy, o_err_act_busy}, 16'h0000);
      cmp({8'h00, o_bank_open}, 16'h0000);
      dpr_host_i.op(`DPR_CMD_ACT, 3'h7, 16'h0000, 6);
      cmp({8'h00, o_bank_open}, 16'h0080);
      $display("reset test done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    error_cnt = 0;
    checked = 0;
    i_arst_n = 1'b0;
    i_al = 4'h1;
    i_cl = 4'h3;
    i_bl8 = 1'b1;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_explicit;
    t_auto(4'h1, 4'h3, 1'b1);
    t_auto(4'h2, 4'h4, 1'b0);
    t_auto(4'h0, 4'h3, 1'b0);
    t_refresh;
    t_reset;
    tally_and_finish;
  end
  initial begin
    #(3000 * 100);
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
endmodule // dpr_ctrl_tb
